// file: include/tp_map.svh
`ifndef TP_MAP_SVH
`define TP_MAP_SVH
// Register index within a profile; byte address = ((channel*6 + profile)*8 + index)*4
`define TP_IDX_EN_PRI      3'h0
`define TP_IDX_SRC         3'h1
`define TP_IDX_MODE        3'h3
`define TP_IDX_CTRL        3'h4
`define TP_IDX_STAT        3'h5
`define TP_PROF_STRIDE_LG2 3
`define TP_NUM_PROF        6
`define TP_NUM_CH          2
`define TP_ADDR_W          12
// Field positions
`define TP_EN_BIT          0
`define TP_PRI_HI          5
`define TP_PRI_LO          1
`define TP_SRC_HI          4
`define TP_MODE_HI         1
// Reset values
`define TP_RST_BYTE        8'h00
`define TP_NONE_IDX        3'h7
// Source codes
`define TP_SRC_FB_CH0      5'h04
`define TP_SRC_FB_CH1      5'h05
`define TP_SRC_UNUSED_10   5'h0a
`define TP_SRC_LAST_VALID  5'h0e
`define TP_NUM_SRC         15
// Mode codes and worst priority value
`define TP_MODE_BUILDOUT   2'h0
`define TP_MODE_UNUSED     2'h2
`define TP_PRI_WORST       5'h1f
`endif

// file: include/tp_pkg.sv
package tp_pkg;
	typedef enum logic [1:0] {
		MODE_BUILDOUT,
		MODE_INT_ZD,
		MODE_UNUSED,
		MODE_EXT_ZD
	} mode_type;

	typedef enum {
		ST_IDLE,
		ST_ACQUIRE,
		ST_LOCKED
	} acq_state_type;

	typedef struct packed {
		logic       enable;
		logic [4:0] priority_val;
		logic [4:0] source;
		logic [1:0] mode;
	} profile_type;

	typedef struct packed {
		logic        valid;
		logic [2:0]  profile;
		logic [4:0]  source;
		logic        hitless;
	} selection_type;
endpackage

// file: tb/ref_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module ref_side_model
(
	// Clock
	input  wire logic       pclk,
	// Bench commands
	input  wire logic [1:0] kick,
	input  wire logic [1:0] lock,
	input  wire logic [1:0] good,
	// Loop side
	output logic      [1:0] switch_req,
	output logic      [1:0] phase_aligned,
	output logic      [1:0] ref_valid
);
	// Loop-side levels change only just after an edge
	always_ff @(posedge pclk)
	begin
		switch_req    <= kick;
		phase_aligned <= lock;
		ref_valid     <= good;
	end
endmodule // ref_side_model
`default_nettype wire

// file: tb/test_translation_profile_select.sv
`timescale 1ns/1ns
`default_nettype none
module test_translation_profile_select;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  kick = 2'b00;
	logic [1:0]  lock = 2'b00;
	logic [1:0]  good = 2'b00;
	logic [1:0]  sw_req;
	logic [1:0]  aligned;
	logic [1:0]  rvalid;
	logic [11:0] act;
	logic [9:0]  tss;
	logic [1:0]  tsv;
	logic [1:0]  slew;
	logic [1:0]  bo;
	logic [1:0]  hl;
	logic [1:0]  mf_pin;
	logic [1:0]  clamp;
	logic [31:0] got;
	logic        last_err;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          cycles = 0;

	always #25 pclk = ~pclk;

	translation_profile_select u_translation_profile_select (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_req(sw_req),
		.phase_aligned(aligned), .ref_valid(rvalid), .profile_active(act), .ts_source(tss),
		.ts_source_valid(tsv), .slew_limit_en(slew), .buildout_insert(bo),
		.hitless_steer(hl), .clamp_en(clamp), .multifunction_status_pin(mf_pin));
	ref_side_model u_ref_side_model (.pclk(pclk), .kick(kick), .lock(lock), .good(good),
		.switch_req(sw_req), .phase_aligned(aligned), .ref_valid(rvalid));

	task automatic give_verdict();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		got = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [11:0] ad(input int c, input int p, input int i);
		return 12'(((c * 6 + p) * 8 + i) * 4);
	endfunction

	task automatic wr(input int c, input int p, input int i, input logic [31:0] d);
		apb(1'b1, ad(c, p, i), d);
	endtask

	task automatic rd(input int c, input int p, input int i, input logic [31:0] e);
		apb(1'b0, ad(c, p, i), 32'h0000_0000);
		chk("register", e, got);
	endtask

	// Poll for the expected active set, then let the routed outputs land
	task automatic wait_act(input logic [11:0] e);
		for (int k = 0; k < 40 && act !== e; k++)
			@(posedge pclk);
		repeat (3) @(posedge pclk);
		chk("profile_active", {20'h0_0000, e}, {20'h0_0000, act});
	endtask

	task automatic bump(input int c);
		@(posedge pclk);
		kick[c] <= 1'b1;
		repeat (6) @(posedge pclk);
		kick[c] <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask

	task automatic t_reset();
		rd(0, 0, 0, 32'h0000_0000);
		chk("active", 32'h0000_0000, {20'h0_0000, act});
		chk("mf_pin", 32'h0000_0000, {30'h0, mf_pin});
		$display("done t_reset");
	endtask

	task automatic t_fields();
		wr(0, 3, 0, 32'h0000_00fe);
		rd(0, 3, 0, 32'h0000_003e);
		wr(0, 3, 1, 32'h0000_00ff);
		rd(0, 3, 1, 32'h0000_001f);
		wr(0, 3, 3, 32'h0000_00ff);
		rd(0, 3, 3, 32'h0000_0003);
		apb(1'b0, ad(0, 3, 2), 32'h0000_0000);
		chk("pslverr", 32'h0000_0001, {31'h0, last_err});
		$display("done t_fields");
	endtask

	task automatic t_select();
		wr(0, 0, 0, 32'h0000_0000);
		wr(0, 1, 1, 32'h0000_0002);
		wr(0, 1, 0, 32'h0000_000b);
		wait_act(12'h002);
		chk("ts_src0", 32'h0000_0002, {27'h0, tss[4:0]});
		chk("mf0", 32'h0000_0001, {31'h0, mf_pin[0]});
		chk("tsv0", 32'h0000_0001, {31'h0, tsv[0]});
		chk("bo0", 32'h0000_0001, {31'h0, bo[0]});
		chk("slew0", 32'h0000_0000, {31'h0, slew[0]});
		wr(0, 2, 1, 32'h0000_0007);
		wr(0, 2, 3, 32'h0000_0001);
		wr(0, 2, 0, 32'h0000_0007);
		wr(0, 4, 1, 32'h0000_0004);
		wr(0, 4, 0, 32'h0000_0001);
		bump(0);
		wait_act(12'h004);
		chk("ts_src0", 32'h0000_0007, {27'h0, tss[4:0]});
		chk("hl0", 32'h0000_0001, {31'h0, hl[0]});
		chk("slew0", 32'h0000_0001, {31'h0, slew[0]});
		chk("bo0", 32'h0000_0001, {31'h0, bo[0]});
		$display("done t_select");
	endtask

	task automatic t_cross();
		wr(1, 0, 1, 32'h0000_0004);
		wr(1, 0, 3, 32'h0000_0003);
		wr(1, 0, 0, 32'h0000_0001);
		wait_act(12'h044);
		chk("ts_src1", 32'h0000_0004, {27'h0, tss[9:5]});
		chk("hl1", 32'h0000_0001, {31'h0, hl[1]});
		good <= 2'b11;
		repeat (8) @(posedge pclk);
		chk("mf_valid", 32'h0000_0003, {30'h0, mf_pin});
		good <= 2'b00;
		repeat (8) @(posedge pclk);
		chk("mf_invalid", 32'h0000_0003, {30'h0, mf_pin});
		rd(1, 0, 5, 32'h0000_0003);
		wr(1, 0, 4, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk("clamp", 32'h0000_0002, {30'h0, clamp});
		lock <= 2'b10;
		repeat (8) @(posedge pclk);
		chk("hl_locked", 32'h0000_0001, {30'h0, hl});
		chk("bo_locked", 32'h0000_0001, {30'h0, bo});
		chk("slew_locked", 32'h0000_0001, {30'h0, slew});
		$display("done t_cross");
	endtask

	task automatic t_none();
		wr(0, 1, 0, 32'h0000_0000);
		wr(0, 2, 0, 32'h0000_0000);
		wr(0, 4, 0, 32'h0000_0000);
		wr(1, 0, 0, 32'h0000_0000);
		wait_act(12'h000);
		chk("mf_none", 32'h0000_0000, {30'h0, mf_pin});
		chk("tsv_none", 32'h0000_0000, {30'h0, tsv});
		$display("done t_none");
	endtask

	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_select();
		t_cross();
		t_none();
		give_verdict();
	end
endmodule // test_translation_profile_select
`default_nettype wire

// file: verilog/translation_profile_select.sv
// The APB slave port and the address map are this design's own decisions.
`include "tp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module translation_profile_select
(
	// APB
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Loop control and status per channel
	input  wire logic [1:0]           switch_req,
	input  wire logic [1:0]           phase_aligned,
	input  wire logic [1:0]           ref_valid,
	output logic      [11:0]          profile_active,
	output logic      [9:0]           ts_source,
	output logic      [1:0]           ts_source_valid,
	output logic      [1:0]           slew_limit_en,
	output logic      [1:0]           buildout_insert,
	output logic      [1:0]           hitless_steer,
	output logic      [1:0]           clamp_en,
	output logic      [1:0]           multifunction_status_pin
);
	localparam int NP = `TP_NUM_PROF;
	localparam int NC = `TP_NUM_CH;

	logic [1:0]  sw_s1_q;
	logic [1:0]  sw_s2_q;
	logic [1:0]  al_s1_q;
	logic [1:0]  al_s2_q;
	logic [1:0]  rv_s1_q;
	logic [1:0]  rv_s2_q;
	logic [1:0]  sw_prev_q;
	logic [7:0]  en_pri_q [NC*NP];
	logic [4:0]  src_q    [NC*NP];
	logic [1:0]  mode_q   [NC*NP];
	logic [1:0]  clamp_q;

	// Source code legality for a channel
	function automatic logic src_ok(input logic [4:0] code, input int ch);
		logic ok;
		ok = (code <= `TP_SRC_LAST_VALID) && (code != `TP_SRC_UNUSED_10);
		if (code == `TP_SRC_FB_CH0)
			ok = (ch == 1);
		if (code == `TP_SRC_FB_CH1)
			ok = (ch == 0);
		return ok;
	endfunction

	// One-hot active vector of a channel
	function automatic logic [NP-1:0] prof_decode(input logic en, input logic [2:0] idx);
		logic [NP-1:0] v;
		v = '0;
		for (int p = 0; p < NP; p++)
			v[p] = en && (idx == 3'(p));
		return v;
	endfunction

	// Address decode: {channel*6 + profile, index}
	logic [3:0] slot;
	logic [2:0] ridx;
	logic       hit;
	assign slot = paddr[8:2+`TP_PROF_STRIDE_LG2];
	assign ridx = paddr[4:2];
	assign hit  = (slot < 4'(NC*NP)) && (paddr[1:0] == 2'h0) &&
	              (paddr[11:9] == 3'h0) &&
	              ((ridx == `TP_IDX_EN_PRI) || (ridx == `TP_IDX_SRC) ||
	               (ridx == `TP_IDX_MODE) || (ridx == `TP_IDX_CTRL) ||
	               (ridx == `TP_IDX_STAT));
	logic access;
	assign access = psel && penable && pready;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sw_s1_q <= 2'h0;
			sw_s2_q <= 2'h0;
			al_s1_q <= 2'h0;
			al_s2_q <= 2'h0;
			rv_s1_q <= 2'h0;
			rv_s2_q <= 2'h0;
			sw_prev_q <= 2'h0;
		end
		else
		begin
			sw_s1_q <= switch_req;
			sw_s2_q <= sw_s1_q;
			al_s1_q <= phase_aligned;
			al_s2_q <= al_s1_q;
			rv_s1_q <= ref_valid;
			rv_s2_q <= rv_s1_q;
			sw_prev_q <= sw_s2_q;
		end
	end

	// Profile registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NC*NP; i++)
			begin
				en_pri_q[i] <= `TP_RST_BYTE;
				src_q[i]    <= 5'h00;
				mode_q[i]   <= `TP_MODE_BUILDOUT;
			end
			clamp_q <= 2'h0;
		end
		else if (access && pwrite && hit)
		begin
			case (ridx)
				`TP_IDX_EN_PRI: en_pri_q[slot] <= {2'h0, pwdata[`TP_PRI_HI:0]};
				`TP_IDX_SRC:    src_q[slot]    <= pwdata[`TP_SRC_HI:0];
				`TP_IDX_MODE:   mode_q[slot]   <= pwdata[`TP_MODE_HI:0];
				`TP_IDX_CTRL:   clamp_q[slot >= 4'(NP)] <= pwdata[0];
				default:        clamp_q <= clamp_q;
			endcase
		end
	end

	// Per-channel selection
	logic [2:0] cur_q [NC];
	logic [2:0] best  [NC];
	tp_pkg::acq_state_type st_q [NC];

	genvar c;
	generate
		for (c = 0; c < NC; c++)
		begin : g_ch
			always_comb
			begin
				logic [4:0] bp;
				logic [3:0] k;
				k = 4'h0;
				bp = `TP_PRI_WORST;
				best[c] = `TP_NONE_IDX;
				for (int p = 0; p < NP; p++)
				begin
					k = 4'(c*NP + p);
					// Enabled with a legal source only, lowest priority value wins, lowest index on tie
					if (en_pri_q[k][`TP_EN_BIT] && src_ok(src_q[k], c) &&
					    (best[c] == `TP_NONE_IDX ||
					     en_pri_q[k][`TP_PRI_HI:`TP_PRI_LO] < bp))
					begin
						bp = en_pri_q[k][`TP_PRI_HI:`TP_PRI_LO];
						best[c] = 3'(p);
					end
				end
			end

			logic [3:0] ck;
			logic       cur_en;
			logic       hitl;
			assign ck     = 4'(c*NP) + {1'b0, cur_q[c]};
			assign cur_en = (cur_q[c] != `TP_NONE_IDX) && en_pri_q[ck][`TP_EN_BIT] &&
			                src_ok(src_q[ck], c);
			assign hitl   = (cur_q[c] != `TP_NONE_IDX) &&
			                (mode_q[ck] != `TP_MODE_BUILDOUT);

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					cur_q[c] <= `TP_NONE_IDX;
				else if (!cur_en || (sw_s2_q[c] && !sw_prev_q[c]))
					cur_q[c] <= best[c];
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					st_q[c] <= tp_pkg::ST_IDLE;
				else
				begin
					case (st_q[c])
						tp_pkg::ST_IDLE:
							if (cur_en)
								st_q[c] <= tp_pkg::ST_ACQUIRE;
						tp_pkg::ST_ACQUIRE:
							if (!cur_en)
								st_q[c] <= tp_pkg::ST_IDLE;
							else if (al_s2_q[c])
								st_q[c] <= tp_pkg::ST_LOCKED;
						tp_pkg::ST_LOCKED:
							if (!cur_en)
								st_q[c] <= tp_pkg::ST_IDLE;
						default:
							st_q[c] <= tp_pkg::ST_IDLE;
					endcase
					// New profile restarts acquisition from its own settings
					if (cur_en && cur_q[c] != best[c] && sw_s2_q[c] && !sw_prev_q[c])
						st_q[c] <= tp_pkg::ST_ACQUIRE;
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					profile_active[c*NP +: NP] <= '0;
					ts_source[c*5 +: 5]       <= 5'h00;
					ts_source_valid[c]        <= 1'b0;
					multifunction_status_pin[c] <= 1'b0;
					buildout_insert[c]        <= 1'b0;
					slew_limit_en[c]          <= 1'b0;
					hitless_steer[c]          <= 1'b0;
					clamp_en[c]               <= 1'b0;
				end
				else
				begin
					profile_active[c*NP +: NP] <= prof_decode(cur_en, cur_q[c]);
					ts_source[c*5 +: 5] <= cur_en ? src_q[ck] : 5'h00;
					ts_source_valid[c] <= cur_en;
					multifunction_status_pin[c] <= cur_en;
					buildout_insert[c] <= (st_q[c] == tp_pkg::ST_ACQUIRE);
					slew_limit_en[c] <= (st_q[c] == tp_pkg::ST_ACQUIRE) && hitl;
					hitless_steer[c] <= (st_q[c] == tp_pkg::ST_ACQUIRE) && hitl;
					clamp_en[c] <= clamp_q[c];
				end
			end
		end
	endgenerate

	// APB read and answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite && hit)
			begin
				case (ridx)
					`TP_IDX_EN_PRI: prdata <= {24'h00_0000, en_pri_q[slot]};
					`TP_IDX_SRC:    prdata <= {27'h000_0000, src_q[slot]};
					`TP_IDX_MODE:   prdata <= {30'h0000_0000, mode_q[slot]};
					`TP_IDX_CTRL:   prdata <= {31'h0000_0000, clamp_q[slot >= 4'(NP)]};
					default:        prdata <= {29'h0000_0000,
					                           rv_s2_q[slot >= 4'(NP)],
					                           profile_active[slot],
					                           src_ok(src_q[slot], int'(slot >= 4'(NP)))};
				endcase
			end
		end
	end

	// Assertions
	property p_disabled_never_active;
		@(posedge pclk) disable iff (!presetn)
		profile_active[1] |-> $past(en_pri_q[1][`TP_EN_BIT]);
	endproperty
	a_disabled_never_active: assert property (p_disabled_never_active)
		else $error("disabled profile became active");

	property p_one_hot_active;
		@(posedge pclk) disable iff (!presetn)
		$onehot0(profile_active[NP-1:0]) && $onehot0(profile_active[2*NP-1:NP]);
	endproperty
	a_one_hot_active: assert property (p_one_hot_active)
		else $error("more than one active profile");

	property p_pin_follows_active;
		@(posedge pclk) disable iff (!presetn)
		multifunction_status_pin[0] == (|profile_active[NP-1:0]);
	endproperty
	a_pin_follows_active: assert property (p_pin_follows_active)
		else $error("active flag mismatch");

	property p_none_enabled;
		@(posedge pclk) disable iff (!presetn)
		(best[0] == `TP_NONE_IDX) [*3] |-> (profile_active[NP-1:0] == '0);
	endproperty
	a_none_enabled: assert property (p_none_enabled)
		else $error("active without enabled profile");

	property p_buildout_no_slew;
		@(posedge pclk) disable iff (!presetn)
		buildout_insert[0] && !hitless_steer[0] |-> !slew_limit_en[0];
	endproperty
	a_buildout_no_slew: assert property (p_buildout_no_slew)
		else $error("slew limiter on during buildout");

	property p_hitless_slew;
		@(posedge pclk) disable iff (!presetn)
		hitless_steer[0] |-> slew_limit_en[0] && buildout_insert[0];
	endproperty
	a_hitless_slew: assert property (p_hitless_slew)
		else $error("hitless without slew limiter");

	property p_source_routed;
		@(posedge pclk) disable iff (!presetn)
		ts_source_valid[0] |-> ts_source[4:0] != `TP_SRC_FB_CH0;
	endproperty
	a_source_routed: assert property (p_source_routed)
		else $error("illegal feedback source on channel zero");

	property p_source_routed_ch1;
		@(posedge pclk) disable iff (!presetn)
		ts_source_valid[1] |-> ts_source[9:5] != `TP_SRC_FB_CH1;
	endproperty
	a_source_routed_ch1: assert property (p_source_routed_ch1)
		else $error("illegal feedback source on channel one");

	property p_apb_answer;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("no ready after setup");
endmodule // translation_profile_select
`default_nettype wire
